// >>> verilog/tmrcmp_pkg.sv
package tmrcmp_pkg;
   // Register byte addresses on the APB.
   localparam logic [7:0] ADDR_CONTROL    = 8'h00;
   localparam logic [7:0] ADDR_COUNTER    = 8'h04;
   localparam logic [7:0] ADDR_COMPARE_A  = 8'h08;
   localparam logic [7:0] ADDR_COMPARE_B  = 8'h0c;
   localparam logic [7:0] ADDR_CAPTURE    = 8'h10;
   localparam logic [7:0] ADDR_FLAGS      = 8'h14;
   localparam logic [7:0] ADDR_FORCE      = 8'h18;
   localparam logic [7:0] ADDR_PORT       = 8'h1c;

   // Control register fields.
   localparam int CTL_WGM_LSB     = 0;
   localparam int CTL_COMA_LSB    = 4;
   localparam int CTL_COMB_LSB    = 6;
   localparam int CTL_RUN_BIT     = 8;

   // Flag register bits.
   localparam int FLG_OVF   = 0;
   localparam int FLG_CMPA  = 1;
   localparam int FLG_CMPB  = 2;
   localparam int FLG_CAP   = 3;

   // Port register bits.
   localparam int PRT_OUT_A = 0;
   localparam int PRT_DIR_A = 1;
   localparam int PRT_OUT_B = 2;
   localparam int PRT_DIR_B = 3;

   localparam logic [3:0]  WGM_NORMAL      = 4'h0;
   localparam logic [3:0]  WGM_CLR_CMPA    = 4'h4;
   localparam logic [3:0]  WGM_CLR_CAPTURE = 4'hc;
   localparam logic [1:0]  ACT_NONE        = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE      = 2'h1;
   localparam logic [1:0]  ACT_CLEAR       = 2'h2;
   localparam logic [1:0]  ACT_SET         = 2'h3;
   localparam logic [15:0] COUNT_MAX       = 16'hffff;
   localparam logic [15:0] COUNT_BOTTOM    = 16'h0000;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
endpackage

// >>> verilog/tmrcmp_top.sv
// Overview of operation
// - A counter write blocks every compare match in the next timer tick, even stopped.
// - Clear-on-match: counter written to top skips top match, runs to 0xFFFF.
// - Output state keeps its value across waveform mode changes.
// - Output action select is unbuffered; applies from the next match.
// - Reset clears the compare output state to zero.
// - Nonzero action select overrides port output value; direction stays from port bit.
// - Compare output reaches the pin only when direction selects output.
// - Action select never touches the capture unit.
// - Action zero leaves output state unchanged on matches.
// - Force strobe in non-PWM modes applies the selected action at once.
// - Counting depends on waveform mode only, not on action select.
// - Normal mode: count up always, wrap 0xFFFF to 0x0000, never clear on match.
// - Normal mode: overflow flag set as counter becomes zero; hardware only sets it.
// - Overflow flag clears when its interrupt is serviced.
// - Normal mode accepts counter writes at any time.
// - Clear-on-match: clear at compare A (mode 4) or capture value (mode 12).
// - Clear-on-match: reaching top sets compare A flag or capture flag.
// - Top is unbuffered; a top below count runs through 0xFFFF first.
// - Toggle action in clear-on-match toggles output A every match.
// - Clear-on-match: overflow flag set when counter passes max to zero.
// - A compare match sets the compare flag at the next timer tick.
// - Force updates output state only; no flag, no counter change.
// - Compare flags clear on interrupt service or by writing one.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tmrcmp_top (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Prescaled timer tick, one-cycle pulse from the prescaler.
   input  wire logic        timer_tick,
   // Capture value from the input capture unit.
   input  wire logic        capture_load,
   input  wire logic [15:0] capture_in,
   // Interrupt service acknowledges, one-cycle pulses.
   input  wire logic        ack_overflow,
   input  wire logic        ack_compare_a,
   input  wire logic        ack_compare_b,
   input  wire logic        ack_capture,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Port pins and flags.
   output logic             pin_a_out,
   output logic             pin_a_oe,
   output logic             pin_b_out,
   output logic             pin_b_oe,
   output logic             overflow_flag,
   output logic             compare_a_flag,
   output logic             compare_b_flag,
   output logic             capture_flag
);
   logic [3:0]  waveform_mode_select;
   logic [1:0]  output_action_select_a;
   logic [1:0]  output_action_select_b;
   logic        run;
   logic [15:0] counter_value;
   logic [15:0] compare_value_a;
   logic [15:0] compare_value_b;
   logic [15:0] capture_value;
   logic [3:0]  port_bits;
   logic        compare_output_a;
   logic        compare_output_b;
   logic        block_match;
   logic        match_a_pend;
   logic        match_b_pend;
   logic        top_cap_pend;

   logic        access;
   logic        wr;
   logic        mapped;
   logic        tick;
   logic        clear_on_match_mode;
   logic        non_pwm;
   logic [15:0] top_value;
   logic        match_a;
   logic        match_b;
   logic        at_top;
   logic        wr_counter;
   logic        wr_flags;
   logic        force_a;
   logic        force_b;
   logic [15:0] next_counter;

   assign access     = psel & penable;
   assign wr         = access & pwrite;
   assign tick       = timer_tick & run;
   assign wr_counter = wr & (paddr == tmrcmp_pkg::ADDR_COUNTER);
   assign wr_flags   = wr & (paddr == tmrcmp_pkg::ADDR_FLAGS);
   assign clear_on_match_mode = (waveform_mode_select == tmrcmp_pkg::WGM_CLR_CMPA) |
                                (waveform_mode_select == tmrcmp_pkg::WGM_CLR_CAPTURE);
   assign non_pwm    = clear_on_match_mode | (waveform_mode_select == tmrcmp_pkg::WGM_NORMAL);
   assign force_a    = wr & (paddr == tmrcmp_pkg::ADDR_FORCE) & non_pwm & pwdata[0];
   assign force_b    = wr & (paddr == tmrcmp_pkg::ADDR_FORCE) & non_pwm & pwdata[1];
   assign top_value  = (waveform_mode_select == tmrcmp_pkg::WGM_CLR_CAPTURE) ?
                       capture_value : compare_value_a;
   // Matches come straight from the live registers; nothing is buffered.
   assign match_a    = (counter_value == compare_value_a) & ~block_match;
   assign match_b    = (counter_value == compare_value_b) & ~block_match;
   assign at_top     = clear_on_match_mode & (counter_value == top_value) & ~block_match;

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         tmrcmp_pkg::ADDR_CONTROL,
         tmrcmp_pkg::ADDR_COUNTER,
         tmrcmp_pkg::ADDR_COMPARE_A,
         tmrcmp_pkg::ADDR_COMPARE_B,
         tmrcmp_pkg::ADDR_CAPTURE,
         tmrcmp_pkg::ADDR_FLAGS,
         tmrcmp_pkg::ADDR_FORCE,
         tmrcmp_pkg::ADDR_PORT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Counting sequence depends on the mode field alone.
   always_comb begin
      next_counter = counter_value + 16'h0001;
      if (at_top) begin
         next_counter = tmrcmp_pkg::COUNT_BOTTOM;
      end
   end

   // Control register.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         waveform_mode_select   <= tmrcmp_pkg::WGM_NORMAL;
         output_action_select_a <= tmrcmp_pkg::ACT_NONE;
         output_action_select_b <= tmrcmp_pkg::ACT_NONE;
         run                    <= 1'b0;
      end else if (wr & (paddr == tmrcmp_pkg::ADDR_CONTROL)) begin
         waveform_mode_select   <= pwdata[tmrcmp_pkg::CTL_WGM_LSB +: 4];
         output_action_select_a <= pwdata[tmrcmp_pkg::CTL_COMA_LSB +: 2];
         output_action_select_b <= pwdata[tmrcmp_pkg::CTL_COMB_LSB +: 2];
         run                    <= pwdata[tmrcmp_pkg::CTL_RUN_BIT];
      end
   end

   // Compare and port registers.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         compare_value_a <= tmrcmp_pkg::COUNT_BOTTOM;
         compare_value_b <= tmrcmp_pkg::COUNT_BOTTOM;
         port_bits       <= 4'h0;
      end else if (wr) begin
         if (paddr == tmrcmp_pkg::ADDR_COMPARE_A) begin
            compare_value_a <= pwdata[15:0];
         end
         if (paddr == tmrcmp_pkg::ADDR_COMPARE_B) begin
            compare_value_b <= pwdata[15:0];
         end
         if (paddr == tmrcmp_pkg::ADDR_PORT) begin
            port_bits <= pwdata[3:0];
         end
      end
   end

   // Capture value is written by software in mode 12, or loaded by the capture unit otherwise.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         capture_value <= tmrcmp_pkg::COUNT_BOTTOM;
      end else if (wr & (paddr == tmrcmp_pkg::ADDR_CAPTURE) &
                   (waveform_mode_select == tmrcmp_pkg::WGM_CLR_CAPTURE)) begin
         capture_value <= pwdata[15:0];
      end else if (capture_load & (waveform_mode_select != tmrcmp_pkg::WGM_CLR_CAPTURE)) begin
         capture_value <= capture_in;
      end
   end

   // Counter: software writes win and are accepted at any time.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         counter_value <= tmrcmp_pkg::COUNT_BOTTOM;
      end else if (wr_counter) begin
         counter_value <= pwdata[15:0];
      end else if (tick) begin
         counter_value <= next_counter;
      end
   end

   // Match blocking lasts until the next timer tick has passed.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         block_match <= 1'b0;
      end else if (wr_counter) begin
         block_match <= 1'b1;
      end else if (timer_tick) begin
         block_match <= 1'b0;
      end
   end

   // Matches seen on a tick raise flags on the following tick.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         match_a_pend <= 1'b0;
         match_b_pend <= 1'b0;
         top_cap_pend <= 1'b0;
      end else if (tick) begin
         match_a_pend <= match_a;
         match_b_pend <= match_b;
         top_cap_pend <= at_top & (waveform_mode_select == tmrcmp_pkg::WGM_CLR_CAPTURE);
      end
   end

   // Flags: set wins over clear.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         overflow_flag  <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
         capture_flag   <= 1'b0;
      end else begin
         if (tick & (next_counter == tmrcmp_pkg::COUNT_BOTTOM) &
             (counter_value == tmrcmp_pkg::COUNT_MAX)) begin
            overflow_flag <= 1'b1;
         end else if (ack_overflow | (wr_flags & pwdata[tmrcmp_pkg::FLG_OVF])) begin
            overflow_flag <= 1'b0;
         end
         if (tick & match_a_pend) begin
            compare_a_flag <= 1'b1;
         end else if (ack_compare_a | (wr_flags & pwdata[tmrcmp_pkg::FLG_CMPA])) begin
            compare_a_flag <= 1'b0;
         end
         if (tick & match_b_pend) begin
            compare_b_flag <= 1'b1;
         end else if (ack_compare_b | (wr_flags & pwdata[tmrcmp_pkg::FLG_CMPB])) begin
            compare_b_flag <= 1'b0;
         end
         if ((tick & top_cap_pend) |
             (capture_load & (waveform_mode_select != tmrcmp_pkg::WGM_CLR_CAPTURE))) begin
            capture_flag <= 1'b1;
         end else if (ack_capture | (wr_flags & pwdata[tmrcmp_pkg::FLG_CAP])) begin
            capture_flag <= 1'b0;
         end
      end
   end

   function automatic logic apply_action(input logic cur, input logic [1:0] act);
      logic res;
      res = cur;
      unique case (act)
         tmrcmp_pkg::ACT_NONE:   res = cur;
         tmrcmp_pkg::ACT_TOGGLE: res = ~cur;
         tmrcmp_pkg::ACT_CLEAR:  res = 1'b0;
         tmrcmp_pkg::ACT_SET:    res = 1'b1;
      endcase
      return res;
   endfunction

   // Output states: untouched by mode changes, only by matches or forces.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         compare_output_a <= 1'b0;
         compare_output_b <= 1'b0;
      end else begin
         if (force_a | (tick & match_a & non_pwm)) begin
            compare_output_a <= apply_action(compare_output_a, output_action_select_a);
         end
         if (force_b | (tick & match_b & non_pwm)) begin
            compare_output_b <= apply_action(compare_output_b, output_action_select_b);
         end
      end
   end

   // Pin drive: waveform overrides the port value, direction comes from the port bit.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_a_out <= 1'b0;
         pin_a_oe  <= 1'b0;
         pin_b_out <= 1'b0;
         pin_b_oe  <= 1'b0;
      end else begin
         pin_a_out <= (output_action_select_a != tmrcmp_pkg::ACT_NONE) ?
                      compare_output_a : port_bits[tmrcmp_pkg::PRT_OUT_A];
         pin_b_out <= (output_action_select_b != tmrcmp_pkg::ACT_NONE) ?
                      compare_output_b : port_bits[tmrcmp_pkg::PRT_OUT_B];
         pin_a_oe  <= port_bits[tmrcmp_pkg::PRT_DIR_A];
         pin_b_oe  <= port_bits[tmrcmp_pkg::PRT_DIR_B];
      end
   end

   // APB answers in the access cycle; reads are registered in the setup cycle.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prdata  <= tmrcmp_pkg::ZERO_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= tmrcmp_pkg::ZERO_WORD;
         if (psel & ~penable & ~pwrite) begin
            unique case (paddr)
               tmrcmp_pkg::ADDR_CONTROL:   prdata <= {23'h0, run, output_action_select_b,
                                                      output_action_select_a, waveform_mode_select};
               tmrcmp_pkg::ADDR_COUNTER:   prdata <= {16'h0, counter_value};
               tmrcmp_pkg::ADDR_COMPARE_A: prdata <= {16'h0, compare_value_a};
               tmrcmp_pkg::ADDR_COMPARE_B: prdata <= {16'h0, compare_value_b};
               tmrcmp_pkg::ADDR_CAPTURE:   prdata <= {16'h0, capture_value};
               tmrcmp_pkg::ADDR_FLAGS:     prdata <= {28'h0, capture_flag, compare_b_flag,
                                                      compare_a_flag, overflow_flag};
               tmrcmp_pkg::ADDR_PORT:      prdata <= {26'h0, compare_output_b, compare_output_a,
                                                      port_bits};
               default:                    prdata <= tmrcmp_pkg::ZERO_WORD;
            endcase
         end
      end
   end

   property p_block_set;
      @(posedge sys_clk) disable iff (sys_rst)
         wr_counter |=> block_match;
   endproperty
   a_block_set: assert property (p_block_set) else $error("counter write did not arm blocking");

   property p_block;
      @(posedge sys_clk) disable iff (sys_rst)
         (block_match && tick && counter_value == compare_value_a) |=> !match_a_pend;
   endproperty
   a_block: assert property (p_block) else $error("match not blocked after counter write");

   property p_ovf;
      @(posedge sys_clk) disable iff (sys_rst)
         (tick && !wr_counter && counter_value == tmrcmp_pkg::COUNT_MAX && !at_top) |=> overflow_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not set on wrap");

   property p_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
         (tick && !wr_counter && waveform_mode_select == tmrcmp_pkg::WGM_NORMAL)
         |=> counter_value == $past(counter_value) + 16'h0001;
   endproperty
   a_wrap: assert property (p_wrap) else $error("normal mode count not incrementing");

   property p_top_clear;
      @(posedge sys_clk) disable iff (sys_rst)
         (tick && !wr_counter && at_top) |=> counter_value == tmrcmp_pkg::COUNT_BOTTOM;
   endproperty
   a_top_clear: assert property (p_top_clear) else $error("counter not cleared at top");

   property p_force;
      @(posedge sys_clk) disable iff (sys_rst)
         (force_a && !tick) |=> $stable(counter_value) && !$rose(compare_a_flag);
   endproperty
   a_force: assert property (p_force) else $error("force changed counter or flag");

   property p_act0;
      @(posedge sys_clk) disable iff (sys_rst)
         (output_action_select_a == tmrcmp_pkg::ACT_NONE) |=> $stable(compare_output_a);
   endproperty
   a_act0: assert property (p_act0) else $error("action zero changed output");

   property p_toggle;
      @(posedge sys_clk) disable iff (sys_rst)
         (tick && match_a && clear_on_match_mode && !force_a &&
          output_action_select_a == tmrcmp_pkg::ACT_TOGGLE) |=> compare_output_a != $past(compare_output_a);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output did not toggle on match");

   property p_pin;
      @(posedge sys_clk) disable iff (sys_rst)
         (output_action_select_a != tmrcmp_pkg::ACT_NONE) ##1 $stable(output_action_select_a)
         |-> pin_a_out == $past(compare_output_a);
   endproperty
   a_pin: assert property (p_pin) else $error("pin not driven from output state");

   property p_flag_set;
      @(posedge sys_clk) disable iff (sys_rst)
         (tick && match_a_pend) |=> compare_a_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("compare flag not set");
endmodule
`default_nettype wire

// >>> verif/tmrcmp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmrcmp_pin_model (
   // Driver side of the port pin.
   input  wire logic drive_val,
   input  wire logic drive_en,
   // Resolved wire, pulled low while nobody drives it.
   output logic      level
);
   assign level = drive_en ? drive_val : 1'b0;
endmodule
`default_nettype wire

// >>> verif/tmrcmp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tmrcmp_top_tb;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        timer_tick = 1'b0;
   logic        capture_load = 1'b0;
   logic [15:0] capture_in = 16'h0000;
   logic        ack_overflow = 1'b0;
   logic        ack_compare_a = 1'b0;
   logic        ack_compare_b = 1'b0;
   logic        ack_capture = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   wire  [31:0] prdata;
   wire         pready, pslverr, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
   wire         overflow_flag, compare_a_flag, compare_b_flag, capture_flag, level_a;
   int          fails = 0;
   int          cmp_count = 0;
   int          top, cnt, st, i, k;
   logic [15:0] lfsr = 16'h0060;
   logic [31:0] rd;
   logic        er;
   logic [1:0]  acts [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
   int          exp_q [$];

   tmrcmp_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .capture_load(capture_load),
      .capture_in(capture_in), .ack_overflow(ack_overflow), .ack_compare_a(ack_compare_a),
      .ack_compare_b(ack_compare_b), .ack_capture(ack_capture), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
      .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag),
      .capture_flag(capture_flag));
   tmrcmp_pin_model pin_a (.drive_val(pin_a_out), .drive_en(pin_a_oe), .level(level_a));

   always #20 sys_clk = ~sys_clk;

   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] ctl(input logic run, input logic [1:0] act, input logic [3:0] mode);
      return {23'h0, run, 2'h0, act, mode};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 50) chk(1'b0, 1'b1, "pready wait");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         timer_tick <= 1'b1;
         @(posedge sys_clk);
         timer_tick <= 1'b0;
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic ack(input logic [3:0] m);
      @(posedge sys_clk);
      {ack_capture, ack_compare_b, ack_compare_a, ack_overflow} <= m;
      @(posedge sys_clk);
      {ack_capture, ack_compare_b, ack_compare_a, ack_overflow} <= 4'h0;
   endtask
   task automatic end_of_test;
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(20000 * 40);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rchk(tmrcmp_pkg::ADDR_PORT, 32'h0, "port after reset");
      settle(1);
      chk(pin_a_out, 1'b0, "pin after reset");
      chk({pin_b_oe, pin_b_out, compare_b_flag}, 3'h0, "b side after reset");
      rchk(8'h20, 32'h0, "unmapped read");
      chk(er, 1'b1, "unmapped error");
      $display("Test reset done");
      // Normal mode wrap and overflow flag.
      lfsr = nxt(lfsr);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b1, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_NORMAL));
      wr(tmrcmp_pkg::ADDR_COUNTER, {16'h0, 16'hfff8 + 16'(lfsr[2:0])});
      tick(7 - int'(lfsr[2:0]));
      settle(1);
      chk(overflow_flag, 1'b0, "ovf before wrap");
      tick(1);
      settle(1);
      chk(overflow_flag, 1'b1, "ovf at wrap");
      rchk(tmrcmp_pkg::ADDR_COUNTER, 32'h0, "count after wrap");
      wr(tmrcmp_pkg::ADDR_FLAGS, 32'h1 << tmrcmp_pkg::FLG_OVF);
      settle(1);
      chk(overflow_flag, 1'b0, "ovf write one");
      wr(tmrcmp_pkg::ADDR_COUNTER, {16'h0, tmrcmp_pkg::COUNT_MAX});
      tick(1);
      ack(4'h1);
      settle(1);
      chk(overflow_flag, 1'b0, "ovf serviced");
      $display("Test normal wrap done");
      // Compare flag, no clear in normal mode, write blocking.
      lfsr = nxt(lfsr);
      cnt = 16'h0040 + lfsr[3:0];
      wr(tmrcmp_pkg::ADDR_COMPARE_A, cnt);
      wr(tmrcmp_pkg::ADDR_COUNTER, cnt - 2);
      tick(2);
      settle(1);
      chk(compare_a_flag, 1'b0, "cmp flag early");
      tick(2);
      settle(1);
      chk(compare_a_flag, 1'b1, "cmp flag set");
      rchk(tmrcmp_pkg::ADDR_COUNTER, cnt + 2, "no clear normal");
      wr(tmrcmp_pkg::ADDR_FLAGS, 32'h1 << tmrcmp_pkg::FLG_CMPA);
      settle(1);
      chk(compare_a_flag, 1'b0, "cmp write one");
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_NORMAL));
      wr(tmrcmp_pkg::ADDR_COUNTER, cnt);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b1, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_NORMAL));
      tick(3);
      settle(1);
      chk(compare_a_flag, 1'b0, "blocked match");
      wr(tmrcmp_pkg::ADDR_COMPARE_A, cnt + 4);
      tick(3);
      settle(1);
      chk(compare_a_flag, 1'b1, "match after block");
      ack(4'h2);
      settle(1);
      chk(compare_a_flag, 1'b0, "cmp serviced");
      $display("Test compare flag done");
      // Forced compares with every action, then port override.
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_NORMAL));
      wr(tmrcmp_pkg::ADDR_COUNTER, 32'h0123);
      wr(tmrcmp_pkg::ADDR_FLAGS, 32'hf);
      st = 0;
      for (k = 0; k < 5; k++) begin
         st = (acts[k] == tmrcmp_pkg::ACT_SET) ? 1 : (acts[k] == tmrcmp_pkg::ACT_CLEAR) ? 0 :
              (acts[k] == tmrcmp_pkg::ACT_TOGGLE) ? 1 - st : st;
         exp_q.push_back(st);
      end
      for (k = 0; k < 5; k++) begin
         wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, acts[k], tmrcmp_pkg::WGM_NORMAL));
         wr(tmrcmp_pkg::ADDR_FORCE, 32'h1);
         rchk(tmrcmp_pkg::ADDR_PORT, exp_q.pop_front() << 4, "forced state");
      end
      chk(compare_a_flag, 1'b0, "force sets no flag");
      rchk(tmrcmp_pkg::ADDR_COUNTER, 32'h0123, "force keeps count");
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_SET, tmrcmp_pkg::WGM_NORMAL));
      wr(tmrcmp_pkg::ADDR_FORCE, 32'h1);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_SET, tmrcmp_pkg::WGM_CLR_CMPA));
      rchk(tmrcmp_pkg::ADDR_PORT, 32'h10, "state across mode");
      settle(2);
      chk({pin_a_oe, level_a}, 2'b00, "pin input");
      wr(tmrcmp_pkg::ADDR_PORT, (32'h1 << tmrcmp_pkg::PRT_DIR_A) | (32'h1 << tmrcmp_pkg::PRT_OUT_B) |
         (32'h1 << tmrcmp_pkg::PRT_DIR_B));
      settle(2);
      chk({pin_a_oe, pin_a_out, pin_b_oe, pin_b_out}, 4'hf, "override");
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_CLR_CMPA));
      settle(2);
      chk(level_a, 1'b0, "port value");
      $display("Test force and port done");
      // Clear-on-match on compare A with toggle then clear.
      lfsr = nxt(lfsr);
      top = 2 + lfsr[2:0];
      cnt = 0;
      st = 1;
      wr(tmrcmp_pkg::ADDR_COMPARE_A, top);
      wr(tmrcmp_pkg::ADDR_COUNTER, 32'h0);
      wr(tmrcmp_pkg::ADDR_FLAGS, 32'hf);
      for (k = 0; k < 2; k++) begin
         wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b1, acts[2 - k], tmrcmp_pkg::WGM_CLR_CMPA));
         for (i = 0; i < 2 * top + 3; i++) begin
            tick(1);
            cnt = (cnt == top) ? 0 : cnt + 1;
            if (cnt == 0) st = (k == 0) ? 1 - st : 0;
            rchk(tmrcmp_pkg::ADDR_COUNTER, cnt, "clear count");
            if (cnt == 1) rchk(tmrcmp_pkg::ADDR_PORT, (st << 4) | 32'he, "clear state");
         end
      end
      chk({compare_a_flag, compare_b_flag, overflow_flag}, 3'b110, "clear flags");
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_CLR_CMPA));
      wr(tmrcmp_pkg::ADDR_COUNTER, 32'hfffd);
      wr(tmrcmp_pkg::ADDR_COMPARE_A, 32'h1);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b1, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_CLR_CMPA));
      tick(3);
      rchk(tmrcmp_pkg::ADDR_COUNTER, 32'h0, "top below count");
      chk(overflow_flag, 1'b1, "clear overflow");
      $display("Test clear on compare A done");
      // Capture path unaffected by actions, then clear on capture value.
      lfsr = nxt(lfsr);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_TOGGLE, tmrcmp_pkg::WGM_NORMAL));
      @(posedge sys_clk);
      capture_in <= lfsr;
      capture_load <= 1'b1;
      @(posedge sys_clk);
      capture_load <= 1'b0;
      rchk(tmrcmp_pkg::ADDR_CAPTURE, {16'h0, lfsr}, "capture value");
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b0, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_CLR_CAPTURE));
      wr(tmrcmp_pkg::ADDR_CAPTURE, 32'h3);
      wr(tmrcmp_pkg::ADDR_COUNTER, 32'h0);
      wr(tmrcmp_pkg::ADDR_FLAGS, 32'hf);
      wr(tmrcmp_pkg::ADDR_CONTROL, ctl(1'b1, tmrcmp_pkg::ACT_NONE, tmrcmp_pkg::WGM_CLR_CAPTURE));
      tick(4);
      rchk(tmrcmp_pkg::ADDR_COUNTER, 32'h0, "clear on capture");
      tick(1);
      rchk(tmrcmp_pkg::ADDR_COUNTER, 32'h1, "count after top");
      chk(capture_flag, 1'b1, "capture top flag");
      $display("Test clear on capture done");
      end_of_test();
   end
endmodule
`default_nettype wire
